// >>> core/strap_defs.vh
`ifndef STRAP_DEFS_VH
`define STRAP_DEFS_VH

// APB register byte offsets
`define ADDR_STRAP_VALUE   12'h000
`define ADDR_CFG_OVERRIDE  12'h004
`define ADDR_BOOT_STATUS   12'h008

// Strap value register bit positions
`define BIT_SUPPLY_V       0
`define BIT_BOOT_SEL       1
`define BIT_BOOT_AUX       2
`define BIT_LOG_TIMING     3
`define BIT_SDIO_TIMING    4
`define STRAP_COUNT        5

// Override register fields
`define BIT_OVR_VSEL_EN    0
`define BIT_OVR_VSEL       1
`define BIT_OVR_SDIO_EN    2
`define BIT_OVR_SDIO_IN    3
`define BIT_OVR_SDIO_OUT   4
`define OVR_WIDTH          5
`define OVR_RESET          5'h00

// Boot status register bits
`define BIT_ST_LOG_EN      0
`define BIT_ST_BOOT_FLASH  1
`define BIT_ST_CAPTURED    2

// Pull direction per strap, 1 = pull-up; bit order as strap value register
`define STRAP_PULL_UP      5'h1a

// Settle time for the weak pulls after reset release, in ns
`define PULL_SETTLE_NS     200
`define CLK_PERIOD_NS      50
`define PULL_SETTLE_CYC    ((`PULL_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// >>> core/strap_capture.v
`timescale 1ns/100ps
`include "strap_defs.vh"

module strap_capture (
    input  wire                      clk_in,
    input  wire                      rst_n_in,
    input  wire [`STRAP_COUNT-1:0]   strap_pin_in,
    output reg  [`STRAP_COUNT-1:0]   strap_val_out,
    output reg                       captured_out,
    output reg  [`STRAP_COUNT-1:0]   pull_en_out,
    output reg  [`STRAP_COUNT-1:0]   pull_up_out
);

    reg [3:0] settle_r;

    // Pulls stay on until the sample is taken so floating pins read their defaults
    always @(posedge clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            settle_r      <= 4'h0;
            captured_out  <= 1'b0;
            strap_val_out <= 5'h00;
            pull_en_out   <= 5'h1f;
            pull_up_out   <= `STRAP_PULL_UP;
        end else if (!captured_out) begin
            if (settle_r == `PULL_SETTLE_CYC - 1) begin
                strap_val_out <= strap_pin_in;
                captured_out  <= 1'b1;
                pull_en_out   <= 5'h00;
            end else begin
                settle_r <= settle_r + 4'h1;
            end
        end
    end

endmodule

// >>> core/strap_decode.v
`timescale 1ns/100ps
`include "strap_defs.vh"

module strap_decode (
    input  wire [`STRAP_COUNT-1:0] strap_val_in,
    input  wire [`OVR_WIDTH-1:0]   ovr_in,
    output wire                    boot_flash_out,
    output wire                    boot_download_out,
    output wire                    log_en_out,
    output wire                    vsel_1v8_out,
    output wire                    sdio_in_rise_out,
    output wire                    sdio_out_rise_out
);

    wire sel = strap_val_in[`BIT_BOOT_SEL];
    wire aux = strap_val_in[`BIT_BOOT_AUX];

    assign boot_flash_out    = sel;
    assign boot_download_out = ~sel & ~aux;
    assign log_en_out        = strap_val_in[`BIT_LOG_TIMING];
    assign vsel_1v8_out      = ovr_in[`BIT_OVR_VSEL_EN] ? ovr_in[`BIT_OVR_VSEL]
                               : strap_val_in[`BIT_SUPPLY_V];
    assign sdio_in_rise_out  = ovr_in[`BIT_OVR_SDIO_EN] ? ovr_in[`BIT_OVR_SDIO_IN]
                               : strap_val_in[`BIT_LOG_TIMING];
    assign sdio_out_rise_out = ovr_in[`BIT_OVR_SDIO_EN] ? ovr_in[`BIT_OVR_SDIO_OUT]
                               : strap_val_in[`BIT_SDIO_TIMING];

endmodule

// >>> core/strap_latch_top.v
// Behaviour
// - Five straps readable in strap value register
// - Latch straps at reset, hold until the next reset
// - Weak pulls enabled while reset active
// - After reset, pins return to normal use
// - Supply strap 1 selects 1.8 V flash
// - Boot select 1 flash; both 0 download
// - Log strap 1 enables boot UART log
// - Two straps choose SDIO input/output edges
// - Firmware may override supply and SDIO timing
`timescale 1ns/100ps
`include "strap_defs.vh"

module strap_latch_top (
    input  wire        clk_in,
    input  wire        arst_n_in,
    input  wire        supply_voltage_strap_in,
    input  wire        boot_select_strap_in,
    input  wire        boot_aux_strap_in,
    input  wire        log_timing_strap_in,
    input  wire        sdio_timing_strap_in,
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    output reg  [4:0]  strap_pull_en_out,
    output reg  [4:0]  strap_pull_up_out,
    output reg         strap_func_en_out,
    output reg         boot_flash_out,
    output reg         boot_download_out,
    output reg         uart0_tx_line_log_en_out,
    output reg         flash_vsel_1v8_out,
    output reg         sdio_in_rise_out,
    output reg         sdio_out_rise_out
);

    reg        rst_s1_r;
    reg        rst_n_r;
    reg [4:0]  ovr_r;
    wire [4:0] strap_val;
    wire       captured;
    wire [4:0] pull_en;
    wire [4:0] pull_up;
    wire       d_flash;
    wire       d_dl;
    wire       d_log;
    wire       d_vsel;
    wire       d_in_r;
    wire       d_out_r;

    // Reset release through two flops
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            rst_s1_r <= 1'b0;
            rst_n_r  <= 1'b0;
        end else begin
            rst_s1_r <= 1'b1;
            rst_n_r  <= rst_s1_r;
        end
    end

    // relies on the outside party holding levels until capture
    strap_capture u_cap (
        .clk_in        (clk_in),
        .rst_n_in      (rst_n_r),
        .strap_pin_in  ({sdio_timing_strap_in, log_timing_strap_in, boot_aux_strap_in,
                         boot_select_strap_in, supply_voltage_strap_in}),
        .strap_val_out (strap_val),
        .captured_out  (captured),
        .pull_en_out   (pull_en),
        .pull_up_out   (pull_up)
    );

    strap_decode u_dec (
        .strap_val_in      (strap_val),
        .ovr_in            (ovr_r),
        .boot_flash_out    (d_flash),
        .boot_download_out (d_dl),
        .log_en_out        (d_log),
        .vsel_1v8_out      (d_vsel),
        .sdio_in_rise_out  (d_in_r),
        .sdio_out_rise_out (d_out_r)
    );

    // Pulls forced on while the raw reset is low, before the synchroniser releases
    always @(posedge clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
            strap_pull_en_out <= 5'h1f;
            strap_pull_up_out <= `STRAP_PULL_UP;
            strap_func_en_out <= 1'b0;
        end else begin
            strap_pull_en_out <= pull_en;
            strap_pull_up_out <= pull_up;
            strap_func_en_out <= captured;
        end
    end

    // Decoded settings registered; held until captured so early boot sees defaults only
    always @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            boot_flash_out           <= 1'b0;
            boot_download_out        <= 1'b0;
            uart0_tx_line_log_en_out <= 1'b0;
            flash_vsel_1v8_out       <= 1'b0;
            sdio_in_rise_out         <= 1'b0;
            sdio_out_rise_out        <= 1'b0;
        end else if (captured) begin
            boot_flash_out           <= d_flash;
            boot_download_out        <= d_dl;
            uart0_tx_line_log_en_out <= d_log;
            flash_vsel_1v8_out       <= d_vsel;
            sdio_in_rise_out         <= d_in_r;
            sdio_out_rise_out        <= d_out_r;
        end
    end

    // APB slave, zero wait states; unmapped addresses answer with an error
    wire acc     = psel_in & ~penable_in;
    wire hit_val = paddr_in == `ADDR_STRAP_VALUE;
    wire hit_ovr = paddr_in == `ADDR_CFG_OVERRIDE;
    wire hit_st  = paddr_in == `ADDR_BOOT_STATUS;

    always @(posedge clk_in or negedge rst_n_r) begin
        if (!rst_n_r) begin
            ovr_r       <= `OVR_RESET;
            prdata_out  <= 32'h0000_0000;
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= acc;
            pslverr_out <= acc & ~(hit_val | hit_ovr | hit_st);
            if (acc && !pwrite_in) begin
                if (hit_val)
                    prdata_out <= {27'h0, strap_val};
                else if (hit_ovr)
                    prdata_out <= {27'h0, ovr_r};
                else if (hit_st)
                    prdata_out <= {29'h0, captured, boot_flash_out, uart0_tx_line_log_en_out};
                else
                    prdata_out <= 32'h0000_0000;
            end
            // Write lands on the completing edge, when pready is seen high
            if (psel_in && penable_in && pready_out && pwrite_in && hit_ovr)
                ovr_r <= pwdata_in[4:0];
        end
    end

endmodule

// >>> verif/strap_partner.sv
`timescale 1ns/100ps
module strap_partner (
    input  wire        clk_in,
    input  wire  [4:0] pull_en_in,
    input  wire  [4:0] pull_up_in,
    input  wire  [4:0] drive_en_in,
    input  wire  [4:0] drive_val_in,
    output logic [4:0] pin_out
);
    // Lines nobody holds wander, so a missed pull never reads as a lucky constant
    logic [4:0] float_r = 5'h15;
    always @(posedge clk_in) float_r <= ~float_r;
    assign pin_out = (drive_en_in & drive_val_in) | (~drive_en_in & pull_en_in & pull_up_in)
                   | (~drive_en_in & ~pull_en_in & float_r);
endmodule

// >>> verif/strap_latch_top_assertions.sv
`timescale 1ns/100ps
`include "strap_defs.vh"
module strap_latch_checker (
    input wire       clk_in,
    input wire       arst_n_in,
    input wire       psel_in,
    input wire       penable_in,
    input wire [11:0] paddr_in,
    input wire       pready_out,
    input wire       pslverr_out,
    input wire [4:0] strap_pull_en_out,
    input wire       strap_func_en_out,
    input wire       boot_flash_out,
    input wire       boot_download_out,
    input wire       uart0_tx_line_log_en_out
);
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!arst_n_in);
    sequence s_setup; psel_in && !penable_in; endsequence
    sequence s_answer; pready_out && psel_in && penable_in; endsequence
    property p_answer; s_setup |=> s_answer; endproperty
    a_answer: assert property (p_answer) else $error("no answer after setup");
    property p_ready; pready_out |-> psel_in && penable_in; endproperty
    a_ready: assert property (p_ready) else $error("stray ready");
    property p_err; pready_out && paddr_in > `ADDR_BOOT_STATUS |-> pslverr_out; endproperty
    a_err: assert property (p_err) else $error("unmapped without error");
    property p_cap; $rose(arst_n_in) |-> ##[4:14] strap_func_en_out; endproperty
    a_cap: assert property (p_cap) else $error("capture late");
    property p_hold; strap_func_en_out && $past(strap_func_en_out) |->
        $stable({boot_flash_out, boot_download_out, uart0_tx_line_log_en_out}); endproperty
    a_hold: assert property (p_hold) else $error("boot bits moved");
    property p_stay; $rose(strap_func_en_out) |=> strap_func_en_out [*8]; endproperty
    a_stay: assert property (p_stay) else $error("function enable dropped");
    property p_off; strap_func_en_out |-> strap_pull_en_out == 5'h00; endproperty
    a_off: assert property (p_off) else $error("pulls left on");
    property p_excl; !(boot_flash_out && boot_download_out); endproperty
    a_excl: assert property (p_excl) else $error("two boot modes");
endmodule
bind strap_latch_top strap_latch_checker u_chk (.clk_in(clk_in), .arst_n_in(arst_n_in), .psel_in(psel_in),
    .penable_in(penable_in), .paddr_in(paddr_in), .pready_out(pready_out), .pslverr_out(pslverr_out),
    .strap_pull_en_out(strap_pull_en_out), .strap_func_en_out(strap_func_en_out), .boot_flash_out(boot_flash_out),
    .boot_download_out(boot_download_out), .uart0_tx_line_log_en_out(uart0_tx_line_log_en_out));

// >>> verif/test_strap_latch_top.sv
`timescale 1ns/100ps
`include "strap_defs.vh"
module test_strap_latch_top;
    logic        clk_in = 0, arst_n_in = 0, psel = 0, penable = 0, pwrite = 0, er;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, rd, st;
    logic [4:0]  drv_en = 0, drv_val = 0, pins, v, pen, pup;
    wire  [31:0] prdata;
    wire         prdy, perr, func, fl, dl, lg, vs, ir, orr;
    int          error_cnt = 0, num_checks = 0;
    logic [4:0]  vals [4] = '{5'h1a, 5'h00, 5'h15, 5'h0b};
    always #25 clk_in = ~clk_in;
    strap_latch_top uut (.clk_in(clk_in), .arst_n_in(arst_n_in), .supply_voltage_strap_in(pins[0]),
        .boot_select_strap_in(pins[1]), .boot_aux_strap_in(pins[2]), .log_timing_strap_in(pins[3]),
        .sdio_timing_strap_in(pins[4]), .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(prdy), .pslverr_out(perr), .strap_pull_en_out(pen),
        .strap_pull_up_out(pup), .strap_func_en_out(func), .boot_flash_out(fl), .boot_download_out(dl),
        .uart0_tx_line_log_en_out(lg), .flash_vsel_1v8_out(vs), .sdio_in_rise_out(ir), .sdio_out_rise_out(orr));
    strap_partner u_pin (.clk_in(clk_in), .pull_en_in(pen), .pull_up_in(pup), .drive_en_in(drv_en),
        .drive_val_in(drv_val), .pin_out(pins));
    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value %s exp %h got %h", nm, exp, got);
        end
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_in);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
        @(posedge clk_in);
        penable <= 1;
        // Ready is awaited, never assumed; the watchdog ends a hang
        do @(posedge clk_in); while (prdy !== 1'b1);
        rd = prdata;
        er = perr;
        {psel, penable} <= 2'b00;
    endtask
    task complete_run;
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        repeat (3000) @(posedge clk_in);
        error_cnt++;
        complete_run;
    end
    initial begin
        for (int i = 0; i < 4; i++) begin
            v = vals[i];
            @(posedge clk_in);
            {arst_n_in, drv_en, drv_val} <= {1'b0, i ? 5'h1f : 5'h00, v};
            repeat (8) @(posedge clk_in);
            chk("pull_en", 5'h1f, pen);
            chk("pull_up", `STRAP_PULL_UP, pup);
            arst_n_in <= 1;
            repeat (16) @(posedge clk_in);
            {drv_en, drv_val} <= {5'h1f, ~v};
            repeat (4) @(posedge clk_in);
            apb(0, `ADDR_STRAP_VALUE, 0);
            chk("straps", {27'h0, v}, rd);
            chk("pulls", 5'h00, pen);
            chk("func", 1, func);
            chk("flash", v[1], fl);
            chk("dload", !v[1] && !v[2], dl);
            chk("log", v[3], lg);
            chk("vsel", v[0], vs);
            chk("sdio", {v[3], v[4]}, {ir, orr});
            st = 0;
            st[`BIT_ST_CAPTURED] = 1;
            st[`BIT_ST_BOOT_FLASH] = v[1];
            st[`BIT_ST_LOG_EN] = v[3];
            apb(0, `ADDR_BOOT_STATUS, 0);
            chk("status", st, rd);
        end
        apb(1, `ADDR_STRAP_VALUE, 32'hffffffff);
        apb(0, `ADDR_STRAP_VALUE, 0);
        chk("ro", {27'h0, v}, rd);
        apb(1, `ADDR_CFG_OVERRIDE, 32'h00000005);
        apb(0, `ADDR_CFG_OVERRIDE, 0);
        chk("ovr", 32'h00000005, rd);
        chk("ovr_out", 3'b000, {vs, ir, orr});
        apb(1, `ADDR_CFG_OVERRIDE, 32'h00000016);
        apb(0, `ADDR_CFG_OVERRIDE, 0);
        chk("ovr_sdio", 3'b101, {vs, ir, orr});
        apb(0, 12'h00c, 0);
        chk("unmapped_err", 1, er);
        chk("unmapped_data", 0, rd);
        complete_run;
    end
endmodule
